// ### rtl/pol_cfg_map.svh
`ifndef POL_CFG_MAP_SVH
`define POL_CFG_MAP_SVH
// Command codes of the configuration words
`define CMD_USER_CFG     8'hd1
`define CMD_GROUP_CFG    8'hd3
`define CMD_OK_DELAY     8'hd4
`define CMD_RAMP_GAIN    8'hd5
`define CMD_INDUCTOR     8'hd6
// Field positions in misc_user_configuration
`define UC_MIN_DUTY_HI   15
`define UC_MIN_DUTY_LO   11
`define UC_DRIVE_EN      10
`define UC_MIN_DUTY_EN   7
`define UC_OK_PUSH_PULL  2
`define UC_EXT_TEMP_EN   1
`define UC_EXT_TEMP_FLT  0
// Field positions in group_bus_rail_phase_config
`define GC_POS_HI        15
`define GC_POS_LO        13
`define GC_RAIL_HI       12
`define GC_RAIL_LO       8
`define GC_PHASES_HI     3
`define GC_PHASES_LO     0
// Writable bit masks; the rest reads as zero
`define UC_MASK          16'hfc87
`define GC_MASK          16'hff0f
// Reset values
`define UC_RESET         16'h0000
`define GC_RESET         16'h0000
`define OKD_RESET        16'h0000
`define GAIN_RESET       8'h00
`define IND_RESET        16'h0000
// Timing
`define CLK_PERIOD_NS    50
`define OK_MS_NS         1000000
`define OK_DELAY_MAX_MS  5000
`define PWM_STEPS        512
`endif

// ### rtl/pol_cfg_pkg.sv
package pol_cfg_pkg;
  // Output-ok timer states
  typedef enum logic [2:0] {
    OK_LOW  = 3'b001,
    OK_WAIT = 3'b010,
    OK_HIGH = 3'b100
  } ok_state_e;
  // Phase counts of a rail
  typedef enum logic [2:0] {
    PH_TWO   = 3'b001,
    PH_FOUR  = 3'b011,
    PH_SIX   = 3'b101,
    PH_EIGHT = 3'b111
  } phases_e;
  typedef logic [12:0] ms_t;      // Delay in whole milliseconds
endpackage

// ### rtl/pwm_min_duty.sv
`timescale 1ns/1ns
`include "pol_cfg_map.svh"
// Period counter and comparator with a duty floor and drive gate
module pwm_min_duty #(
  parameter int STEPS = `PWM_STEPS
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [8:0] duty_i,     // Requested duty in steps of the period
  input  wire logic [4:0] floor_i,    // Floor field value
  input  wire logic       floor_en_i, // Floor active
  input  wire logic       drive_en_i, // Drive allowed
  output logic            pwm_o
);
  logic [8:0] cnt_q, cnt_d;           // Position in the period
  logic       pwm_q, pwm_d;
  logic [8:0] floor_steps;            // Floor in steps
  logic [8:0] eff;                    // Duty after the floor

  // Next period position and drive level
  always_comb begin
    cnt_d = (cnt_q == 9'(STEPS - 1)) ? 9'h000 : cnt_q + 9'h001;
    floor_steps = {3'h0, floor_i, 1'b0} + 9'h002;
    eff = (floor_en_i && duty_i < floor_steps) ? floor_steps : duty_i;
    pwm_d = drive_en_i && (cnt_q < eff);
  end

  // Register period and drive
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 9'h000;
      pwm_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pwm_q <= pwm_d;
    end
  end
  assign pwm_o = pwm_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_min_duty_floor: assert property (
    drive_en_i && floor_en_i && cnt_q < floor_steps |=> pwm_q)
    else $error("duty floor not honoured");
  a_drive_off: assert property (!drive_en_i |=> !pwm_q)
    else $error("drive active while disabled");
  c_floor_used: cover property (floor_en_i && duty_i < floor_steps && pwm_q);
endmodule // pwm_min_duty

// ### rtl/ok_delay_timer.sv
`timescale 1ns/1ns
`include "pol_cfg_map.svh"
// Waits the programmed delay after the output is above threshold
module ok_delay_timer #(
  parameter int MS_CYCLES = 20000
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              above_i,  // Output above threshold, from a pin
  input  wire pol_cfg_pkg::ms_t  delay_i,  // Delay in milliseconds
  output logic                   ok_o      // Output ok, decoded from state
);
  logic                   s1_q, s2_q;       // Two-stage synchroniser
  pol_cfg_pkg::ok_state_e st_q, st_d;
  logic [31:0]            pre_q, pre_d;     // Millisecond prescaler
  pol_cfg_pkg::ms_t       ms_q, ms_d;       // Milliseconds elapsed

  // Next state of the timer
  always_comb begin
    st_d = st_q;
    pre_d = pre_q;
    ms_d = ms_q;
    case (st_q)
      pol_cfg_pkg::OK_LOW: begin
        pre_d = 32'h0;
        ms_d = '0;
        if (s2_q) st_d = pol_cfg_pkg::OK_WAIT;
      end
      pol_cfg_pkg::OK_WAIT: begin
        if (!s2_q) begin
          st_d = pol_cfg_pkg::OK_LOW;
        end else if (ms_q >= delay_i) begin
          st_d = pol_cfg_pkg::OK_HIGH;
        end else if (pre_q == 32'(MS_CYCLES - 1)) begin
          pre_d = 32'h0;
          ms_d = ms_q + 13'h1;
        end else begin
          pre_d = pre_q + 32'h1;
        end
      end
      pol_cfg_pkg::OK_HIGH: begin
        if (!s2_q) st_d = pol_cfg_pkg::OK_LOW;
      end
      default: st_d = pol_cfg_pkg::OK_LOW;
    endcase
  end

  // Register synchroniser and timer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      st_q <= pol_cfg_pkg::OK_LOW;
      pre_q <= 32'h0;
      ms_q <= '0;
    end else begin
      s1_q <= above_i;
      s2_q <= s1_q;
      st_q <= st_d;
      pre_q <= pre_d;
      ms_q <= ms_d;
    end
  end
  assign ok_o = (st_q == pol_cfg_pkg::OK_HIGH);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ok_waits_delay: assert property ($rose(ok_o) |-> $past(ms_q) >= $past(delay_i))
    else $error("output ok before delay elapsed");
  a_ok_drops: assert property (!s2_q |=> !ok_o)
    else $error("output ok held with output low");
  c_ok_rise: cover property ($rose(ok_o));
endmodule // ok_delay_timer

// ### rtl/pol_misc_cfg.sv
`timescale 1ns/1ns
`include "pol_cfg_map.svh"
module pol_misc_cfg #(
  parameter int MS_CYCLES = `OK_MS_NS / `CLK_PERIOD_NS  // Clock cycles per millisecond
) (
  input  wire logic        SYS_CLK_I,       // System clock, 20 MHz
  input  wire logic        RST_N_I,         // Asynchronous reset, active low
  input  wire logic [7:0]  CMD_CODE_I,      // Command code of the transfer
  input  wire logic        CMD_WR_I,        // Write strobe, one cycle
  input  wire logic        CMD_RD_I,        // Read strobe, one cycle
  input  wire logic [15:0] CMD_WDATA_I,     // Write data
  output logic      [15:0] CMD_RDATA_O,     // Read data
  output logic             CMD_ACK_O,       // Transfer accepted
  output logic             CMD_NAK_O,       // Unknown command
  input  wire logic [8:0]  DUTY_CMD_I,      // Duty from the control loop
  input  wire logic        VOUT_ABOVE_I,    // Output above threshold, from a pin
  input  wire logic [11:0] INT_TEMP_I,      // Internal sensor reading
  input  wire logic [11:0] EXT_TEMP_I,      // External sensor reading
  output logic             PWM_O,           // Power stage drive
  output logic             OK_PIN_O,        // Output-ok pin level
  output logic             OK_PIN_OE_O,     // Output-ok pin enable
  output logic      [11:0] FAULT_TEMP_O,    // Temperature for fault checks
  output logic             TEMP_COMP_EN_O,  // Current compensation by external sensor
  output logic      [4:0]  RAIL_ID_O,       // Group bus rail identifier
  output logic      [2:0]  PHASE_POS_O,     // Position in group minus one
  output logic      [3:0]  PHASE_COUNT_O,   // Phases on the rail, zero if undefined
  output logic      [7:0]  RAMP_GAIN_O,     // Sharing ramp gain
  output logic             RAMP_SHARE_O,    // Slow sharing ramp active
  output logic             SOFT_OFF_EN_O,   // Soft-off ramps allowed
  output logic      [15:0] INDUCTOR_O       // Inductor value, linear format
);

  // Turns a linear word into whole milliseconds, rounded, capped
  function automatic pol_cfg_pkg::ms_t lin_to_ms(input logic [15:0] v);
    logic [4:0]  e;
    logic [10:0] m;
    logic [31:0] acc;
    logic [4:0]  sh;
    e = v[15:11];
    m = v[10:0];
    acc = 32'h0;
    sh = 5'h00;
    if (m[10]) begin
      acc = 32'h0;                             // Negative reads as zero
    end else if (!e[4]) begin
      acc = {21'h0, m} << e[3:0];              // Whole multiple
    end else begin
      sh = 5'h00 - e;                          // Fractional part to round
      acc = ({21'h0, m} + (32'h1 << (sh - 5'h01))) >> sh;
    end
    if (acc > 32'(`OK_DELAY_MAX_MS)) acc = 32'(`OK_DELAY_MAX_MS);
    return acc[12:0];
  endfunction

  // Configuration words
  logic [15:0] user_q, user_d;              // misc_user_configuration
  logic [15:0] grp_q, grp_d;                // group_bus_rail_phase_config
  logic [15:0] okd_q, okd_d;                // output_ok_delay
  logic [7:0]  gain_q, gain_d;              // sharing_ramp_gain
  logic [15:0] ind_q, ind_d;                // inductor_value
  pol_cfg_pkg::ms_t dly_q, dly_d;           // Delay in milliseconds
  // Command answers
  logic [15:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;
  logic        nak_q, nak_d;
  // Derived outputs
  logic        ok;                          // Output ok from timer
  logic        ok_pin_q, ok_pin_d;
  logic        ok_oe_q, ok_oe_d;
  logic [11:0] ftemp_q, ftemp_d;
  logic [3:0]  phcnt_q, phcnt_d;
  logic        share_q, share_d;            // Rail set up for sharing
  logic        ramp_q, ramp_d;
  logic        soft_q, soft_d;

  // Command decode, write and read
  always_comb begin
    // Hold every word unless a write selects it
    user_d = user_q;
    grp_d = grp_q;
    okd_d = okd_q;
    gain_d = gain_q;
    ind_d = ind_q;
    // Read data stands until the next strobe
    rdata_d = rdata_q;
    // Answers are single-cycle pulses
    ack_d = 1'b0;
    nak_d = 1'b0;
    // A write that meets a read wins and still returns the old word
    if (CMD_WR_I || CMD_RD_I) begin
      ack_d = 1'b1;
      if (CMD_CODE_I == `CMD_USER_CFG) begin
        // Misc user word, reserved bits dropped
        if (CMD_WR_I) user_d = CMD_WDATA_I & `UC_MASK;
        rdata_d = user_q;
      end else if (CMD_CODE_I == `CMD_GROUP_CFG) begin
        // Rail, position and phase word, reserved bits dropped
        if (CMD_WR_I) grp_d = CMD_WDATA_I & `GC_MASK;
        rdata_d = grp_q;
      end else if (CMD_CODE_I == `CMD_OK_DELAY) begin
        // Delay word kept as written, converted downstream
        if (CMD_WR_I) okd_d = CMD_WDATA_I;
        rdata_d = okd_q;
      end else if (CMD_CODE_I == `CMD_RAMP_GAIN) begin
        // Byte command, upper byte reads as zero
        if (CMD_WR_I) gain_d = CMD_WDATA_I[7:0];
        rdata_d = {8'h00, gain_q};
      end else if (CMD_CODE_I == `CMD_INDUCTOR) begin
        // Inductor word kept as written
        if (CMD_WR_I) ind_d = CMD_WDATA_I;
        rdata_d = ind_q;
      end else begin
        ack_d = 1'b0;                                   // Unknown command
        nak_d = 1'b1;
        rdata_d = 16'h0000;
      end
    end
  end

  // Register the configuration words and answers
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      // All words clear: drive off, no sharing, no delay
      user_q <= `UC_RESET;
      grp_q <= `GC_RESET;
      okd_q <= `OKD_RESET;
      gain_q <= `GAIN_RESET;
      ind_q <= `IND_RESET;
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
      nak_q <= 1'b0;
    end else begin
      user_q <= user_d;
      grp_q <= grp_d;
      okd_q <= okd_d;
      gain_q <= gain_d;
      ind_q <= ind_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      nak_q <= nak_d;
    end
  end

  // Derived controls
  always_comb begin
    // Delay word to whole milliseconds for the timer
    dly_d = lin_to_ms(okd_q);
    // Output-ok pin style
    if (user_q[`UC_OK_PUSH_PULL]) begin
      // Push-pull drives both levels
      ok_pin_d = ok;
      ok_oe_d = 1'b1;
    end else begin
      // Open-drain pulls low until ok, then lets go
      ok_pin_d = 1'b0;
      ok_oe_d = !ok;
    end
    // Temperature source for faults
    ftemp_d = user_q[`UC_EXT_TEMP_FLT] ? EXT_TEMP_I : INT_TEMP_I;
    // Phase count decode
    case (grp_q[`GC_PHASES_HI:`GC_PHASES_LO])
      {1'b0, pol_cfg_pkg::PH_TWO}:   phcnt_d = 4'h2;
      {1'b0, pol_cfg_pkg::PH_FOUR}:  phcnt_d = 4'h4;
      {1'b0, pol_cfg_pkg::PH_SIX}:   phcnt_d = 4'h6;
      {1'b0, pol_cfg_pkg::PH_EIGHT}: phcnt_d = 4'h8;
      default:                       phcnt_d = 4'h0;    // Not defined
    endcase
    // Only a defined phase count makes a sharing rail
    share_d = (phcnt_d != 4'h0);
    // Slow sharing ramp until output ok
    ramp_d = share_q && !ok;
    // Soft-off only on a rail of its own
    soft_d = !share_q;
  end

  // Register derived controls
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      // Pin released and soft-off allowed until the first edge
      dly_q <= '0;
      ok_pin_q <= 1'b0;
      ok_oe_q <= 1'b0;
      ftemp_q <= 12'h000;
      phcnt_q <= 4'h0;
      share_q <= 1'b0;
      ramp_q <= 1'b0;
      soft_q <= 1'b1;
    end else begin
      dly_q <= dly_d;
      ok_pin_q <= ok_pin_d;
      ok_oe_q <= ok_oe_d;
      ftemp_q <= ftemp_d;
      phcnt_q <= phcnt_d;
      share_q <= share_d;
      ramp_q <= ramp_d;
      soft_q <= soft_d;
    end
  end

  // Power stage drive with duty floor
  pwm_min_duty #(
    .STEPS      (`PWM_STEPS)
  ) u_pwm (
    .clk_i      (SYS_CLK_I),
    .rst_n_i    (RST_N_I),
    .duty_i     (DUTY_CMD_I),
    .floor_i    (user_q[`UC_MIN_DUTY_HI:`UC_MIN_DUTY_LO]),
    .floor_en_i (user_q[`UC_MIN_DUTY_EN]),
    .drive_en_i (user_q[`UC_DRIVE_EN]),
    .pwm_o      (PWM_O)
  );

  // Output-ok delay
  ok_delay_timer #(
    .MS_CYCLES  (MS_CYCLES)
  ) u_okt (
    .clk_i      (SYS_CLK_I),
    .rst_n_i    (RST_N_I),
    .above_i    (VOUT_ABOVE_I),
    .delay_i    (dly_q),
    .ok_o       (ok)
  );

  // Outputs straight from registers
  assign CMD_RDATA_O = rdata_q;
  assign CMD_ACK_O = ack_q;
  assign CMD_NAK_O = nak_q;
  assign OK_PIN_O = ok_pin_q;
  assign OK_PIN_OE_O = ok_oe_q;
  assign FAULT_TEMP_O = ftemp_q;
  assign TEMP_COMP_EN_O = user_q[`UC_EXT_TEMP_EN];
  assign RAIL_ID_O = grp_q[`GC_RAIL_HI:`GC_RAIL_LO];
  assign PHASE_POS_O = grp_q[`GC_POS_HI:`GC_POS_LO];
  assign PHASE_COUNT_O = phcnt_q;
  assign RAMP_GAIN_O = gain_q;
  assign RAMP_SHARE_O = ramp_q;
  assign SOFT_OFF_EN_O = soft_q;
  assign INDUCTOR_O = ind_q;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Command port, drive, pin, sensor, sharing and phase checks
  a_reserved_zero: assert property (
    CMD_WR_I && CMD_CODE_I == `CMD_USER_CFG |=> (user_q & ~`UC_MASK) == 16'h0000 && CMD_ACK_O)
    else $error("reserved bits kept");
  a_drive_gate: assert property (!user_q[`UC_DRIVE_EN] |=> !PWM_O)
    else $error("drive while disabled");
  a_od_style: assert property (!user_q[`UC_OK_PUSH_PULL] |=> !OK_PIN_O)
    else $error("open-drain pin driven high");
  a_fault_src: assert property (
    user_q[`UC_EXT_TEMP_FLT] |=> FAULT_TEMP_O == $past(EXT_TEMP_I))
    else $error("wrong fault temperature source");
  a_share_ramp: assert property (share_q && !ok |=> RAMP_SHARE_O)
    else $error("sharing ramp not used");
  a_ramp_ends: assert property (ok |=> !RAMP_SHARE_O)
    else $error("sharing ramp after output ok");
  a_soft_off: assert property (share_q |=> !SOFT_OFF_EN_O)
    else $error("soft-off allowed while sharing");
  a_phase_code: assert property (grp_q[3:0] == 4'h5 |=> PHASE_COUNT_O == 4'h6)
    else $error("phase count decode wrong");
  a_gain_write: assert property (
    CMD_WR_I && CMD_CODE_I == `CMD_RAMP_GAIN |=> RAMP_GAIN_O == $past(CMD_WDATA_I[7:0]))
    else $error("ramp gain not stored");
  a_unmapped_nak: assert property (
    CMD_RD_I && CMD_CODE_I == 8'h00 |=> CMD_NAK_O && CMD_RDATA_O == 16'h0000)
    else $error("unknown command not refused");
  a_nak_no_store: assert property (
    CMD_NAK_O |-> user_q == $past(user_q) && grp_q == $past(grp_q) && okd_q == $past(okd_q)
      && gain_q == $past(gain_q) && ind_q == $past(ind_q))
    else $error("refused command changed a word");
  a_answer_single: assert property (CMD_ACK_O |-> !CMD_NAK_O)
    else $error("accept and refuse together");
  // Field, pin and sharing checks
  a_temp_comp_write: assert property (
    CMD_WR_I && CMD_CODE_I == `CMD_USER_CFG |=> TEMP_COMP_EN_O == $past(CMD_WDATA_I[1]))
    else $error("sensor compensation enable not stored");
  a_rail_id_write: assert property (
    CMD_WR_I && CMD_CODE_I == `CMD_GROUP_CFG |=> RAIL_ID_O == $past(CMD_WDATA_I[12:8]))
    else $error("rail identifier not stored");
  a_position_write: assert property (
    CMD_WR_I && CMD_CODE_I == `CMD_GROUP_CFG |=> PHASE_POS_O == $past(CMD_WDATA_I[15:13]))
    else $error("group position not stored");
  a_group_reserved: assert property (
    CMD_WR_I && CMD_CODE_I == `CMD_GROUP_CFG |=> (grp_q & ~`GC_MASK) == 16'h0000)
    else $error("reserved group bits kept");
  a_inductor_write: assert property (
    CMD_WR_I && CMD_CODE_I == `CMD_INDUCTOR |=> INDUCTOR_O == $past(CMD_WDATA_I))
    else $error("inductor value not stored");
  a_delay_write: assert property (
    CMD_WR_I && CMD_CODE_I == `CMD_OK_DELAY |=> okd_q == $past(CMD_WDATA_I))
    else $error("delay word not stored");
  a_pp_drive: assert property (user_q[`UC_OK_PUSH_PULL] |=> OK_PIN_OE_O)
    else $error("push-pull pin not driven");
  a_od_release: assert property (!user_q[`UC_OK_PUSH_PULL] && ok |=> !OK_PIN_OE_O)
    else $error("open-drain pin held while ok");
  a_soft_idle: assert property (!share_q |=> SOFT_OFF_EN_O)
    else $error("soft-off blocked on a single rail");
  a_ramp_idle: assert property (!share_q |=> !RAMP_SHARE_O)
    else $error("sharing ramp on a single rail");
  // Main scenarios
  c_share_ramp: cover property (RAMP_SHARE_O ##1 !RAMP_SHARE_O);
  c_push_pull: cover property (user_q[`UC_OK_PUSH_PULL] && OK_PIN_O);
  c_nak: cover property (CMD_NAK_O);
endmodule // pol_misc_cfg

// ### tb/pmbus_host_model.sv
`timescale 1ns/1ns
// Host that issues word and byte commands on the command port
module pmbus_host_model (
  input  wire logic        clk_i,    // System clock
  output logic      [7:0]  code_o,   // Command code
  output logic             wr_o,     // Write strobe
  output logic             rd_o,     // Read strobe
  output logic      [15:0] wdata_o,  // Write data
  input  wire logic [15:0] rdata_i,  // Read data
  input  wire logic        ack_i,    // Command accepted
  input  wire logic        nak_i     // Command refused
);
  // Idle port with no strobe up
  initial begin
    code_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0000;
  end

  // One strobe cycle, then a bounded wait for the answer
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ack, output logic nak);
    int n;
    @(posedge clk_i);
    #1;
    code_o = code;
    wdata_o = wd;
    wr_o = wr;
    rd_o = !wr;
    @(posedge clk_i);
    #1;
    // Released qualifiers show the inverse, never the old value
    wr_o = 1'b0;
    rd_o = 1'b0;
    code_o = ~code;
    wdata_o = ~wd;
    n = 0;
    while (!(ack_i | nak_i) && n < 4) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    rd = rdata_i;
    ack = ack_i;
    nak = nak_i;
  endtask
endmodule // pmbus_host_model

// ### tb/test_pol_misc_cfg.sv
`timescale 1ns/1ns
// Compares a value with its expectation and logs any mismatch
`define CHECK(got, want) \
  begin \
    check_count++; \
    if ((got) !== (want)) begin \
      miscompares++; \
      $display("mismatch at %0t: got %h expected %h", $time, (got), (want)); \
    end \
  end
// Self-checking bench of the configuration bank
module test_pol_misc_cfg;
  localparam int MS = 8;  // Short millisecond for simulation
  logic        sys_clk, rst_n, cmd_wr, cmd_rd, cmd_ack, cmd_nak, vout_above;
  logic        pwm, ok_pin, ok_pin_oe, temp_comp_en, ramp_share, soft_off_en;
  logic [7:0]  cmd_code, ramp_gain;
  logic [15:0] cmd_wdata, cmd_rdata, inductor;
  logic [8:0]  duty_cmd;
  logic [11:0] int_temp, ext_temp, fault_temp;
  logic [4:0]  rail_id;
  logic [2:0]  phase_pos;
  logic [3:0]  phase_count;
  int          miscompares = 0;
  int          check_count = 0;

  pol_misc_cfg #(.MS_CYCLES(MS)) uut (
    .SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .CMD_CODE_I(cmd_code), .CMD_WR_I(cmd_wr),
    .CMD_RD_I(cmd_rd), .CMD_WDATA_I(cmd_wdata), .CMD_RDATA_O(cmd_rdata),
    .CMD_ACK_O(cmd_ack), .CMD_NAK_O(cmd_nak), .DUTY_CMD_I(duty_cmd),
    .VOUT_ABOVE_I(vout_above), .INT_TEMP_I(int_temp), .EXT_TEMP_I(ext_temp),
    .PWM_O(pwm), .OK_PIN_O(ok_pin), .OK_PIN_OE_O(ok_pin_oe), .FAULT_TEMP_O(fault_temp),
    .TEMP_COMP_EN_O(temp_comp_en), .RAIL_ID_O(rail_id), .PHASE_POS_O(phase_pos),
    .PHASE_COUNT_O(phase_count), .RAMP_GAIN_O(ramp_gain), .RAMP_SHARE_O(ramp_share),
    .SOFT_OFF_EN_O(soft_off_en), .INDUCTOR_O(inductor));

  pmbus_host_model host (
    .clk_i(sys_clk), .code_o(cmd_code), .wr_o(cmd_wr), .rd_o(cmd_rd),
    .wdata_o(cmd_wdata), .rdata_i(cmd_rdata), .ack_i(cmd_ack), .nak_i(cmd_nak));

  // Free-running 50 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Prints counts and verdict, then ends the run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Write a word and let dependent outputs settle
  task automatic wr_reg(input logic [7:0] code, input logic [15:0] d);
    logic [15:0] r;
    logic        a, k;
    host.xfer(1'b1, code, d, r, a, k);
    `CHECK(a, 1'b1)
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // Read a word and compare it
  task automatic rd_chk(input logic [7:0] code, input logic [15:0] want);
    logic [15:0] r;
    logic        a, k;
    host.xfer(1'b0, code, 16'h0000, r, a, k);
    `CHECK(a, 1'b1)
    `CHECK(r, want)
  endtask

  // Reset state and two unmapped commands
  task automatic test_reset();
    logic [7:0]  codes [5] = '{8'hd1, 8'hd3, 8'hd4, 8'hd5, 8'hd6};
    logic [15:0] r;
    logic        a, k;
    foreach (codes[i]) rd_chk(codes[i], 16'h0000);
    `CHECK(soft_off_en, 1'b1)
    `CHECK(ok_pin_oe, 1'b1)
    host.xfer(1'b1, 8'hd2, 16'hffff, r, a, k);
    `CHECK({a, k}, 2'b01)
    foreach (codes[i]) rd_chk(codes[i], 16'h0000);
    host.xfer(1'b0, 8'h00, 16'h0000, r, a, k);
    `CHECK({a, k, r}, 18'h10000)
  endtask

  // Sensor selection and reserved bits of the user word
  task automatic test_user();
    wr_reg(8'hd1, 16'hffff);
    rd_chk(8'hd1, 16'hfc87);
    `CHECK(temp_comp_en, 1'b1)
    `CHECK(fault_temp, ext_temp)
    wr_reg(8'hd1, 16'h0000);
    `CHECK(temp_comp_en, 1'b0)
    `CHECK(fault_temp, int_temp)
  endtask

  // Every phase code with varied rail and position fields
  task automatic test_group();
    logic [3:0]  c;
    logic [15:0] d;
    logic        share;
    for (int k = 0; k < 16; k++) begin
      c = k[3:0];
      d = {c[2:0], {1'b0, c} ^ 5'h15, 4'hf, c};
      share = (c < 4'h8) && c[0];
      wr_reg(8'hd3, d);
      rd_chk(8'hd3, d & 16'hff0f);
      `CHECK(rail_id, d[12:8])
      `CHECK(phase_pos, d[15:13])
      `CHECK(phase_count, share ? c + 4'h1 : 4'h0)
      `CHECK(soft_off_en, !share)
      `CHECK(ramp_share, share)
    end
  endtask

  // Byte gain and inductor word
  task automatic test_gain();
    wr_reg(8'hd5, 16'h1234);
    rd_chk(8'hd5, 16'h0034);
    `CHECK(ramp_gain, 8'h34)
    wr_reg(8'hd6, 16'ha5c3);
    rd_chk(8'hd6, 16'ha5c3);
    `CHECK(inductor, 16'ha5c3)
  endtask

  // Output-ok delay with rounding, ramp mode and pin style
  task automatic test_ok();
    logic [15:0] dly [5] = '{16'h0000, 16'h0003, 16'hf805, 16'hf803, 16'hf802};
    int          ms [5] = '{0, 3, 3, 2, 1};
    int          n;
    wr_reg(8'hd3, 16'h0001);
    wr_reg(8'hd1, 16'h0004);
    foreach (dly[i]) begin
      wr_reg(8'hd4, dly[i]);
      rd_chk(8'hd4, dly[i]);
      `CHECK(ramp_share, 1'b1)
      vout_above = 1'b1;
      n = 0;
      while (ok_pin !== 1'b1 && n < 2000) begin
        @(negedge sys_clk);
        n++;
      end
      `CHECK(n >= ms[i] * MS + 2 && n <= ms[i] * MS + 7, 1'b1)
      `CHECK(ramp_share, 1'b0)
      `CHECK(ok_pin_oe, 1'b1)
      if (i == 4) begin
        wr_reg(8'hd1, 16'h0000);
        `CHECK(ok_pin_oe, 1'b0)
      end
      @(posedge sys_clk);
      #1;
      vout_above = 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
      `CHECK(ok_pin, 1'b0)
    end
  endtask

  // High cycles in one period for drive gate, floor and its enable
  task automatic test_pwm();
    logic [15:0] cfg [6] = '{16'h0000, 16'h0400, 16'h1c80, 16'hfc80, 16'hfc00, 16'h1c80};
    logic [8:0]  dty [6] = '{9'd100, 9'd100, 9'd0, 9'd0, 9'd0, 9'd100};
    int          want [6] = '{0, 100, 8, 64, 0, 100};
    int          n;
    foreach (cfg[i]) begin
      wr_reg(8'hd1, cfg[i]);
      duty_cmd = dty[i];
      repeat (520) @(negedge sys_clk);
      n = 0;
      repeat (512) begin
        @(negedge sys_clk);
        n += (pwm === 1'b1);
      end
      `CHECK(n, want[i])
    end
  endtask

  // Reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    duty_cmd = 9'd0;
    vout_above = 1'b0;
    int_temp = 12'h1c4;
    ext_temp = 12'h5a3;
    repeat (6) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    test_reset();
    test_user();
    test_group();
    test_gain();
    test_ok();
    test_pwm();
    finish_test();
  end

  // Watchdog against a hang
  initial begin
    #(40000 * 50);
    miscompares++;
    finish_test();
  end
endmodule // test_pol_misc_cfg
